// File: hw/axis_params_pkg.sv
// Package: register map, field positions and timing for the axis parameters
package axis_params_pkg;
	// Register byte addresses (printed offsets are indices, address = 4*index)
	localparam logic [7:0] IDX_FREEWHEEL = 8'hCC;
	localparam logic [7:0] IDX_LOAD = 8'hCE;
	localparam logic [7:0] IDX_EXT_ERR = 8'hCF;
	localparam logic [7:0] IDX_DRV_FAULT = 8'hD0;
	localparam logic [7:0] IDX_ENC_COUNT = 8'hD1;
	localparam logic [7:0] IDX_ENC_CLEAR = 8'hD2;
	localparam logic [7:0] IDX_CHOP_STATUS = 8'hD3;
	localparam logic [9:0] ADDR_FREEWHEEL = {IDX_FREEWHEEL, 2'b00};
	localparam logic [9:0] ADDR_LOAD = {IDX_LOAD, 2'b00};
	localparam logic [9:0] ADDR_EXT_ERR = {IDX_EXT_ERR, 2'b00};
	localparam logic [9:0] ADDR_DRV_FAULT = {IDX_DRV_FAULT, 2'b00};
	localparam logic [9:0] ADDR_ENC_COUNT = {IDX_ENC_COUNT, 2'b00};
	localparam logic [9:0] ADDR_ENC_CLEAR = {IDX_ENC_CLEAR, 2'b00};
	localparam logic [9:0] ADDR_CHOP_STATUS = {IDX_CHOP_STATUS, 2'b00};
	// Driver fault field bit positions
	localparam int BIT_STALL = 0;
	localparam int BIT_OVERTEMP = 1;
	localparam int BIT_PREWARN = 2;
	localparam int BIT_SHORT_A = 3;
	localparam int BIT_SHORT_B = 4;
	localparam int BIT_OPEN_A = 5;
	localparam int BIT_OPEN_B = 6;
	localparam int BIT_STANDSTILL = 7;
	// Reset values
	localparam logic [1:0] RST_FREEWHEEL = 2'h0;
	localparam logic [31:0] RST_ENC_COUNT = 32'h00000000;
	// Standstill window in clock cycles
	localparam int STANDSTILL_LOG2 = 20;
	localparam int STANDSTILL_CYCLES = 1 << STANDSTILL_LOG2;
	// Freewheel modes
	typedef enum logic [1:0] {
		FW_NORMAL = 2'b00,
		FW_FREE = 2'b01,
		FW_SHORT_LS = 2'b10,
		FW_SHORT_HS = 2'b11
	} freewheel_e;
endpackage

// File: hw/axis_status_encoder_params.sv
// Axis parameter slice: freewheel, load, error flags, encoder counter
// How it works
// - Freewheel only at standstill, zero standby, quiet mode
// - Read-only load value zero to 1023
// - Extended errors clear on read or motion
// - Fault bit1 overtemp shutdown, bit2 prewarning
// - Fault bits 3,4 short to ground A,B
// - Fault bits 5,6 open load A,B
// - Bit7 standstill after 2^20 idle cycles
// - Signed 32-bit encoder counter, readable and writable
// - Clear counter at zero pass when armed
// - Clear-on-null option self-resets after clearing
`timescale 1ns/1ps
`default_nettype none
module axis_status_encoder_params
	import axis_params_pkg::*;
#(
	parameter int STANDSTILL_WINDOW = STANDSTILL_CYCLES
) (
	input wire logic clk,
	input wire logic rst_b,
	// Classic Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	// Driver and motion status
	input wire logic [9:0] load_meas,
	input wire logic stall_det,
	input wire logic overtemp,
	input wire logic overtemp_warn,
	input wire logic short_a,
	input wire logic short_b,
	input wire logic open_a,
	input wire logic open_b,
	input wire logic step_pulse,
	input wire logic standby_zero,
	input wire logic quiet_pwm_active,
	input wire logic deviation_err,
	input wire logic aux_err,
	input wire logic motion_cmd,
	// Integrated encoder
	input wire logic enc_inc,
	input wire logic enc_dec,
	input wire logic enc_zero,
	// Coil stage control
	output logic [1:0] coil_mode
);
	// Refuse a window the timer cannot count
	if (STANDSTILL_WINDOW < 2) begin : g_bad_window
		$error("STANDSTILL_WINDOW must be at least 2");
	end

	logic [1:0] fw_sel_r, fw_sel_nxt;
	logic [1:0] ext_err_r, ext_err_nxt;
	logic [31:0] enc_cnt_r, enc_cnt_nxt;
	logic enc_arm_r, enc_arm_nxt;
	logic [7:0] fault_r, fault_nxt;
	logic [9:0] load_r, load_nxt;
	logic [1:0] coil_mode_r, coil_mode_nxt;
	logic [31:0] dat_r, dat_nxt;
	logic ack_r, ack_nxt;
	logic err_r, err_nxt;
	logic still;
	logic req, wr, rd, mapped;

	standstill_timer #(
		.WINDOW(STANDSTILL_WINDOW)
	) u_still (
		.clk(clk),
		.rst_b(rst_b),
		.step_pulse(step_pulse),
		.still(still)
	);

	// New request only while no answer is pending, one-cycle ack
	assign req = wb_cyc_i && wb_stb_i && !ack_r && !err_r;
	assign wr = req && wb_we_i;
	assign rd = req && !wb_we_i;

	// Address decode
	always_comb begin
		case (wb_adr_i)
			ADDR_FREEWHEEL, ADDR_LOAD, ADDR_EXT_ERR, ADDR_DRV_FAULT,
			ADDR_ENC_COUNT, ADDR_ENC_CLEAR, ADDR_CHOP_STATUS: begin
				mapped = 1'b1;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// Bus answer and read mux; fault and load reads change nothing
	always_comb begin
		ack_nxt = req && mapped;
		err_nxt = req && !mapped;
		dat_nxt = 32'h00000000;
		if (rd) begin
			case (wb_adr_i)
				ADDR_FREEWHEEL: dat_nxt = {30'h0, fw_sel_r};
				ADDR_LOAD: dat_nxt = {22'h0, load_r};
				ADDR_EXT_ERR: dat_nxt = {30'h0, ext_err_r};
				ADDR_DRV_FAULT: dat_nxt = {24'h0, fault_r};
				ADDR_ENC_COUNT: dat_nxt = enc_cnt_r;
				ADDR_ENC_CLEAR: dat_nxt = {31'h0, enc_arm_r};
				ADDR_CHOP_STATUS: dat_nxt = {30'h0, quiet_pwm_active,
					standby_zero};
				default: dat_nxt = 32'h00000000;
			endcase
		end
	end

	// Freewheel select, written through byte lane 0
	always_comb begin
		fw_sel_nxt = fw_sel_r;
		if (wr && wb_adr_i == ADDR_FREEWHEEL && wb_sel_i[0]) begin
			fw_sel_nxt = wb_dat_i[1:0];
		end
	end

	// Coil stage: freewheel modes need standstill, zero standby, quiet pwm
	always_comb begin
		coil_mode_nxt = FW_NORMAL;
		if (still && standby_zero && quiet_pwm_active) begin
			coil_mode_nxt = fw_sel_r;
		end
	end

	// Extended errors: sticky; a new event wins over the clear
	always_comb begin
		ext_err_nxt = ext_err_r;
		if ((rd && wb_adr_i == ADDR_EXT_ERR) || motion_cmd) begin
			ext_err_nxt = 2'b00;
		end
		ext_err_nxt = ext_err_nxt | {aux_err, deviation_err};
	end

	// Driver fault snapshot; bits 0-6 follow the live driver condition, bit 7 the standstill timer
	always_comb begin
		fault_nxt = 8'h00;
		fault_nxt[BIT_STALL] = stall_det;
		fault_nxt[BIT_OVERTEMP] = overtemp;
		fault_nxt[BIT_PREWARN] = overtemp_warn;
		fault_nxt[BIT_SHORT_A] = short_a;
		fault_nxt[BIT_SHORT_B] = short_b;
		fault_nxt[BIT_OPEN_A] = open_a;
		fault_nxt[BIT_OPEN_B] = open_b;
		fault_nxt[BIT_STANDSTILL] = still;
		load_nxt = load_meas;
	end

	// Encoder counter; zero-pass clear beats a count, host write beats both
	always_comb begin
		enc_cnt_nxt = enc_cnt_r;
		enc_arm_nxt = enc_arm_r;
		if (enc_inc && !enc_dec) begin
			enc_cnt_nxt = enc_cnt_r + 32'h00000001;
		end else if (enc_dec && !enc_inc) begin
			enc_cnt_nxt = enc_cnt_r - 32'h00000001;
		end
		if (enc_arm_r && enc_zero) begin
			enc_cnt_nxt = 32'h00000000;
			enc_arm_nxt = 1'b0;
		end
		if (wr && wb_adr_i == ADDR_ENC_COUNT) begin
			for (int i = 0; i < 4; i++) begin
				if (wb_sel_i[i]) begin
					enc_cnt_nxt[i*8 +: 8] = wb_dat_i[i*8 +: 8];
				end
			end
		end
		if (wr && wb_adr_i == ADDR_ENC_CLEAR && wb_sel_i[0]) begin
			enc_arm_nxt = wb_dat_i[0];
		end
	end

	// Register all state
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fw_sel_r <= RST_FREEWHEEL;
			ext_err_r <= 2'b00;
			enc_cnt_r <= RST_ENC_COUNT;
			enc_arm_r <= 1'b0;
			fault_r <= 8'h00;
			load_r <= 10'h000;
			coil_mode_r <= FW_NORMAL;
			dat_r <= 32'h00000000;
			ack_r <= 1'b0;
			err_r <= 1'b0;
		end else begin
			fw_sel_r <= fw_sel_nxt;
			ext_err_r <= ext_err_nxt;
			enc_cnt_r <= enc_cnt_nxt;
			enc_arm_r <= enc_arm_nxt;
			fault_r <= fault_nxt;
			load_r <= load_nxt;
			coil_mode_r <= coil_mode_nxt;
			dat_r <= dat_nxt;
			ack_r <= ack_nxt;
			err_r <= err_nxt;
		end
	end

	assign wb_dat_o = dat_r;
	assign wb_ack_o = ack_r;
	assign wb_err_o = err_r;
	assign coil_mode = coil_mode_r;

	// Checks next to the logic: coil stage gating
	a_coil_gate: assert property (
		@(posedge clk) disable iff (!rst_b)
		!(still && standby_zero && quiet_pwm_active)
		|=> coil_mode == FW_NORMAL)
		else $error("coil mode left normal outside standstill");
	a_coil_follow: assert property (
		@(posedge clk) disable iff (!rst_b)
		(still && standby_zero && quiet_pwm_active)
		|=> coil_mode == $past(fw_sel_r))
		else $error("coil mode not following freewheel select");

	// Load and extended error flags
	a_load_follow: assert property (
		@(posedge clk) disable iff (!rst_b)
		1'b1 |=> load_r == $past(load_meas))
		else $error("load value not tracking measurement");
	a_ext_clear: assert property (
		@(posedge clk) disable iff (!rst_b)
		(motion_cmd && !deviation_err && !aux_err)
		|=> ext_err_r == 2'b00)
		else $error("extended errors not cleared by motion");
	a_ext_set: assert property (
		@(posedge clk) disable iff (!rst_b)
		deviation_err |=> ext_err_r[0])
		else $error("deviation event did not set its flag");

	// Driver fault bits 1-6 track the live driver levels, bit 7 the standstill timer
	a_overtemp_bit: assert property (
		@(posedge clk) disable iff (!rst_b)
		1'b1 |=> fault_r[BIT_OVERTEMP] == $past(overtemp))
		else $error("overtemp bit wrong");
	a_prewarn_bit: assert property (
		@(posedge clk) disable iff (!rst_b)
		1'b1 |=> fault_r[BIT_PREWARN] == $past(overtemp_warn))
		else $error("prewarning bit wrong");
	a_short_bits: assert property (
		@(posedge clk) disable iff (!rst_b)
		1'b1 |=> fault_r[BIT_SHORT_B:BIT_SHORT_A] ==
		$past({short_b, short_a}))
		else $error("short bits wrong");
	a_open_bits: assert property (
		@(posedge clk) disable iff (!rst_b)
		1'b1 |=> fault_r[BIT_OPEN_B:BIT_OPEN_A] ==
		$past({open_b, open_a}))
		else $error("open load bits wrong");
	a_still_bit: assert property (
		@(posedge clk) disable iff (!rst_b)
		1'b1 |=> fault_r[BIT_STANDSTILL] == $past(still))
		else $error("standstill bit not following timer");
	a_still_clear: assert property (
		@(posedge clk) disable iff (!rst_b)
		step_pulse |=> ##1 !fault_r[BIT_STANDSTILL])
		else $error("standstill bit not cleared by step");

	// Encoder counter and its clear-on-null option
	a_enc_write: assert property (
		@(posedge clk) disable iff (!rst_b)
		(wr && wb_adr_i == ADDR_ENC_COUNT && wb_sel_i == 4'hF)
		|=> enc_cnt_r == $past(wb_dat_i))
		else $error("encoder write lost");
	a_null_clear: assert property (
		@(posedge clk) disable iff (!rst_b)
		(enc_arm_r && enc_zero && !wr)
		|=> enc_cnt_r == 32'h00000000 && !enc_arm_r)
		else $error("zero pass did not clear counter and option");
	a_arm_keep: assert property (
		@(posedge clk) disable iff (!rst_b)
		(enc_arm_r && !enc_zero && !wr) |=> enc_arm_r)
		else $error("clear option dropped without a zero pass");

	// Driver fault reads leave the sticky flags alone
	a_fault_read: assert property (
		@(posedge clk) disable iff (!rst_b)
		(rd && wb_adr_i == ADDR_DRV_FAULT && !motion_cmd)
		|=> ext_err_r ==
		($past(ext_err_r) | $past({aux_err, deviation_err})))
		else $error("fault read had a side effect");

	// Bus answer is a single pulse, data zero outside it
	a_ack_pulse: assert property (
		@(posedge clk) disable iff (!rst_b)
		(wb_ack_o || wb_err_o) |=> !wb_ack_o && !wb_err_o)
		else $error("bus answer longer than one cycle");
	a_dat_idle: assert property (
		@(posedge clk) disable iff (!rst_b)
		!wb_ack_o |-> wb_dat_o == 32'h00000000)
		else $error("read data not zero outside ack");
endmodule
`default_nettype wire

// File: hw/standstill_timer.sv
// Standstill detector: flags no step pulse within a cycle window
`timescale 1ns/1ps
`default_nettype none
module standstill_timer
	import axis_params_pkg::*;
#(
	parameter int WINDOW = STANDSTILL_CYCLES
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic step_pulse,
	output logic still
);
	localparam int CW = $clog2(WINDOW + 1);
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic still_r, still_nxt;

	// A window below two cycles leaves no room to count
	if (WINDOW < 2) begin : g_bad_window
		$error("standstill window too short");
	end

	// Count idle cycles; saturate so the flag stays until a step
	always_comb begin
		cnt_nxt = cnt_r;
		still_nxt = still_r;
		if (step_pulse) begin
			cnt_nxt = '0;
			still_nxt = 1'b0;
		end else if (cnt_r == CW'(WINDOW - 1)) begin
			still_nxt = 1'b1;
		end else begin
			cnt_nxt = cnt_r + CW'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r <= '0;
			still_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			still_r <= still_nxt;
		end
	end

	assign still = still_r;
endmodule
`default_nettype wire

// File: testbench/axis_status_encoder_params_tb.sv
// Testbench: register sequences against the axis parameter slice
`timescale 1ns/1ps
`default_nettype none
module axis_status_encoder_params_tb;
	import axis_params_pkg::*;
	logic clk, rst_b, cyc, stb, we, ack, err, e;
	logic step, sbz, qpw, dev, aux, mot, inc, dec, zro;
	logic [9:0] adr, load;
	logic [3:0] sel;
	logic [31:0] dw, dr, q;
	logic [6:0] flt;
	logic [1:0] coil;
	int error_cnt = 0;
	int cmp_count = 0;

	// Free running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	wb_host_model u_wb_host_model (.clk(clk), .cyc(cyc), .stb(stb),
		.we(we), .adr(adr), .sel(sel), .dat(dw), .dat_i(dr), .ack(ack),
		.err(err));

	// Short window keeps the standstill tests fast
	axis_status_encoder_params #(.STANDSTILL_WINDOW(16))
	u_axis_status_encoder_params (.clk(clk), .rst_b(rst_b),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
		.wb_err_o(err), .load_meas(load), .stall_det(flt[0]),
		.overtemp(flt[1]), .overtemp_warn(flt[2]), .short_a(flt[3]),
		.short_b(flt[4]), .open_a(flt[5]), .open_b(flt[6]),
		.step_pulse(step), .standby_zero(sbz), .quiet_pwm_active(qpw),
		.deviation_err(dev), .aux_err(aux), .motion_cmd(mot),
		.enc_inc(inc), .enc_dec(dec), .enc_zero(zro), .coil_mode(coil));

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		cmp_count++;
		if (g !== x) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, g, x);
		end
	endtask

	task automatic rd(input logic [9:0] a, input logic [31:0] x);
		u_wb_host_model.xfer(1'b0, a, 32'h00000000, q, e);
		chk(q, x);
	endtask

	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		u_wb_host_model.xfer(1'b1, a, d, q, e);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic final_report;
		$display("comparisons %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Watchdog far beyond the fewer than two hundred cycles of the sequence
	initial begin
		#200000;
		error_cnt++;
		final_report();
	end

	// Main sequence
	initial begin
		{rst_b, step, sbz, qpw, dev, aux, mot, inc, dec, zro} <= 10'h000;
		load <= 10'h000;
		flt <= 7'h00;
		tick(6);
		rst_b <= 1'b1;
		rd(ADDR_FREEWHEEL, 32'h00000000);
		rd(ADDR_ENC_COUNT, 32'h00000000);
		tick(20);
		// One fault source at a time, standstill already set
		for (int i = 0; i < 7; i++) begin
			flt <= 7'h01 << i;
			rd(ADDR_DRV_FAULT, (32'h1 << i) | 32'h80);
		end
		flt <= 7'h00;
		step <= 1'b1;
		tick(1);
		step <= 1'b0;
		rd(ADDR_DRV_FAULT, 32'h00000000);
		tick(20);
		rd(ADDR_DRV_FAULT, 32'h00000080);
		load <= 10'h3FF;
		rd(ADDR_LOAD, 32'h000003FF);
		rd(ADDR_LOAD, 32'h000003FF);
		// Every freewheel mode reaches the coils with all gates held; dropping quiet pwm returns normal
		sbz <= 1'b1;
		qpw <= 1'b1;
		rd(ADDR_CHOP_STATUS, 32'h00000003);
		for (int m = 0; m < 4; m++) begin
			wr(ADDR_FREEWHEEL, 32'(m));
			rd(ADDR_FREEWHEEL, 32'(m));
			chk({30'h0, coil}, 32'(m));
		end
		qpw <= 1'b0;
		tick(3);
		chk({30'h0, coil}, 32'h00000000);
		// Extended flags: clear on read, then clear by motion command
		{dev, aux} <= 2'b11;
		tick(1);
		{dev, aux} <= 2'b00;
		rd(ADDR_DRV_FAULT, 32'h00000080);
		rd(ADDR_EXT_ERR, 32'h00000003);
		rd(ADDR_EXT_ERR, 32'h00000000);
		dev <= 1'b1;
		tick(1);
		dev <= 1'b0;
		mot <= 1'b1;
		tick(1);
		mot <= 1'b0;
		rd(ADDR_EXT_ERR, 32'h00000000);
		// Counter wraps past the signed limit
		wr(ADDR_ENC_COUNT, 32'h7FFFFFFE);
		inc <= 1'b1;
		tick(3);
		inc <= 1'b0;
		rd(ADDR_ENC_COUNT, 32'h80000001);
		wr(ADDR_ENC_CLEAR, 32'h00000001);
		rd(ADDR_ENC_CLEAR, 32'h00000001);
		zro <= 1'b1;
		tick(1);
		zro <= 1'b0;
		rd(ADDR_ENC_COUNT, 32'h00000000);
		rd(ADDR_ENC_CLEAR, 32'h00000000);
		dec <= 1'b1;
		tick(1);
		dec <= 1'b0;
		zro <= 1'b1;
		tick(1);
		zro <= 1'b0;
		rd(ADDR_ENC_COUNT, 32'hFFFFFFFF);
		// Unmapped address is refused with zero data
		rd(10'h3FC, 32'h00000000);
		chk({31'h0, e}, 32'h00000001);
		final_report();
	end
endmodule
`default_nettype wire

// File: testbench/wb_host_model.sv
// Host side model: classic Wishbone master issuing single cycles
`timescale 1ns/1ps
`default_nettype none
module wb_host_model (
	input wire logic clk,
	output logic cyc,
	output logic stb,
	output logic we,
	output logic [9:0] adr,
	output logic [3:0] sel,
	output logic [31:0] dat,
	input wire logic [31:0] dat_i,
	input wire logic ack,
	input wire logic err
);
	// Idle bus at time zero
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 10'h000;
		sel = 4'h0;
		dat = 32'h00000000;
	end

	// Answer sampled on the rising edge; request held until then
	task automatic xfer(input logic w, input logic [9:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		dat <= d;
		do @(posedge clk); while (ack !== 1'b1 && err !== 1'b1);
		q = dat_i;
		e = err;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		dat <= ~d; // Released data must not look valid
	endtask
endmodule
`default_nettype wire
